// ===== hw/msfh_frame_handler.sv
// msfh_frame_handler: slave request decode, crc check, reply and refresh
`timescale 1ns/1ps
`default_nettype none
module msfh_frame_handler
#(
  parameter int unsigned REPLY_CYCLES = msfh_pkg::REPLY_CYC,
  parameter int unsigned MS_CYCLES    = msfh_pkg::TICK_MS_CYC,
  parameter int unsigned DEV_WAIT     = 8
) (
  // clock and reset
  input  wire logic        CLOCK,
  input  wire logic        RESET,
  // configuration
  input  wire logic [7:0]  SLAVE_ADDR,
  // received byte stream, frame ends on RX_END
  input  wire logic        RX_VALID,
  input  wire logic [7:0]  RX_DATA,
  input  wire logic        RX_END,
  // reply byte stream
  output logic             TX_VALID,
  output logic [7:0]       TX_DATA,
  output logic             TX_LAST,
  input  wire logic        TX_READY,
  // register read port, address is register number minus one
  output logic             REG_RD,
  output logic             REG_INPUT,
  output logic [15:0]      REG_ADDR,
  input  wire logic [15:0] REG_DATA,
  input  wire logic        REG_DATASET,
  input  wire logic        REG_BAD,
  // broadcast action strobe
  output logic             BCAST_DONE,
  // refresh strobes
  output logic             REFRESH_FAST,
  output logic             REFRESH_HARM,
  output logic             REFRESH_SLOW,
  input  wire logic        CHANGE_EVENT,
  output logic             REFRESH_CHANGE
);
  import msfh_pkg::*;

  if (REPLY_CYCLES < 64 || MS_CYCLES < 1 ||
      DEV_WAIT < 1 || DEV_WAIT > 255) begin
    $error("msfh_frame_handler: unusable parameters");
  end

  // ==========================================================
  // frame receive and reply state
  msfh_state_t state, next_state;
  logic [7:0]  rx_cnt, next_rx_cnt, tx_idx, next_tx_idx;
  logic [7:0]  hdr [REQ_BYTES];
  logic [7:0]  next_hdr [REQ_BYTES];
  logic [15:0] crc, next_crc;
  logic [15:0] tx_crc, next_tx_crc;
  logic [7:0]  nregs, next_nregs;
  logic [15:0] cur, next_cur;
  logic [15:0] word, next_word;
  logic        exc, next_exc;
  logic [7:0]  wait_cnt, next_wait_cnt;
  logic [31:0] lat, next_lat;
  logic        next_tx_valid, next_tx_last, next_reg_rd, next_bcast;
  logic [7:0]  ex_code, next_ex_code, next_tx_data;

  always_comb begin
    next_state    = state;
    next_rx_cnt   = rx_cnt;
    next_hdr      = hdr;
    next_crc      = crc;
    next_tx_crc   = tx_crc;
    next_tx_idx   = tx_idx;
    next_nregs    = nregs;
    next_cur      = cur;
    next_word     = word;
    next_exc      = exc;
    next_ex_code  = ex_code;
    next_wait_cnt = wait_cnt;
    next_lat      = (state == MSFH_IDLE || state == MSFH_RECV) ? 32'h0 :
                    lat + 32'h1;
    next_tx_valid = TX_VALID && !TX_READY;
    next_tx_data  = TX_DATA;
    next_tx_last  = TX_LAST && !TX_READY;
    next_reg_rd   = 1'b0;
    next_bcast    = 1'b0;
    unique case (state)
      MSFH_IDLE, MSFH_RECV: begin
        if (RX_VALID) begin
          next_state = MSFH_RECV;
          if (rx_cnt < 8'(REQ_BYTES))
            next_hdr[rx_cnt[2:0]] = RX_DATA;
          next_crc = msfh_crc(crc, RX_DATA);
          // frame reaching the limit of FRAME_MAX_BYTES bytes is dropped
          if (rx_cnt == 8'(FRAME_MAX_BYTES - 1))
            next_state = MSFH_DROP;
          else
            next_rx_cnt = rx_cnt + 8'h01;
        end
        if (RX_END) begin
          next_rx_cnt = 8'h00;
          next_crc    = CRC_INIT;
          next_state  = MSFH_IDLE;
          // crc over all bytes incl. crc field leaves zero
          if (crc == 16'h0000 && rx_cnt == 8'(REQ_BYTES)) begin
            if (hdr[0] == ADDR_BROADCAST) begin
              next_bcast = 1'b1;
            end else if (hdr[0] == SLAVE_ADDR &&
                         hdr[0] <= ADDR_UNICAST_MAX) begin
              next_cur   = {hdr[2], hdr[3]};
              next_nregs = hdr[5];
              next_exc   = 1'b0;
              if (hdr[1] != FC_READ_HOLDING &&
                  hdr[1] != FC_READ_INPUT) begin
                next_exc     = 1'b1;
                next_ex_code = EXC_ILLEGAL_FUNC;
              end else if (hdr[4] != 8'h00 || hdr[5] == 8'h00 ||
                           hdr[5] > 8'(MAX_REGS)) begin
                next_exc     = 1'b1;
                next_ex_code = EXC_ILLEGAL_ADDR;
              end
              next_tx_crc   = CRC_INIT;
              next_tx_idx   = 8'h00;
              next_wait_cnt = 8'h00;
              next_state    = next_exc ? MSFH_SEND : MSFH_FETCH;
              next_reg_rd   = !next_exc;
            end
          end
        end
      end
      MSFH_DROP: begin
        if (RX_END) begin
          next_rx_cnt = 8'h00;
          next_crc    = CRC_INIT;
          next_state  = MSFH_IDLE;
        end
      end
      MSFH_FETCH: begin
        // device registers take extra wait cycles
        next_wait_cnt = wait_cnt + 8'h01;
        if (REG_BAD) begin
          next_exc     = 1'b1;
          next_ex_code = EXC_ILLEGAL_ADDR;
          next_tx_idx  = 8'h00;
          next_state   = MSFH_SEND;
        end else if (REG_DATASET || wait_cnt >= 8'(DEV_WAIT)) begin
          next_word  = REG_DATA;
          next_state = MSFH_SEND;
        end
      end
      MSFH_SEND: begin
        if (!TX_VALID || TX_READY) begin
          next_tx_valid = 1'b1;
          next_tx_idx   = tx_idx + 8'h01;
          if (tx_idx == 8'h00)
            next_tx_data = hdr[0];
          else if (tx_idx == 8'h01)
            next_tx_data = exc ? (hdr[1] | EXC_BIT) : hdr[1];
          else if (tx_idx == 8'h02)
            next_tx_data = exc ? ex_code : {nregs[6:0], 1'b0};
          else
            next_tx_data = tx_idx[0] ? word[15:8] : word[7:0];
          next_tx_crc = msfh_crc(tx_crc, next_tx_data);
          if (exc && tx_idx == 8'h02)
            next_state = MSFH_CRC;
          else if (!exc && tx_idx >= 8'h03 && !tx_idx[0]) begin
            // both bytes of this word sent
            if (nregs == 8'h01) begin
              next_state = MSFH_CRC;
            end else begin
              next_nregs    = nregs - 8'h01;
              next_cur      = cur + 16'h0001;
              next_wait_cnt = 8'h00;
              next_reg_rd   = 1'b1;
              next_state    = MSFH_FETCH;
            end
          end
        end
      end
      MSFH_CRC: begin
        if (!TX_VALID || TX_READY) begin
          next_tx_valid = 1'b1;
          if (!TX_LAST && tx_idx != 8'hFF) begin
            next_tx_data = tx_crc[7:0];
            next_tx_idx  = 8'hFF;
          end else if (tx_idx == 8'hFF) begin
            next_tx_data = tx_crc[15:8];
            next_tx_last = 1'b1;
            next_tx_idx  = 8'h00;
          end else begin
            next_tx_valid = 1'b0;
            next_state    = MSFH_IDLE;
          end
        end
      end
      default: next_state = MSFH_IDLE;
    endcase
  end

  always_ff @(posedge CLOCK or posedge RESET) begin
    if (RESET) begin
      state     <= MSFH_IDLE;
      rx_cnt    <= 8'h00;
      for (int i = 0; i < REQ_BYTES; i++) hdr[i] <= 8'h00;
      crc       <= CRC_INIT;
      tx_crc    <= CRC_INIT;
      tx_idx    <= 8'h00;
      nregs     <= 8'h00;
      cur       <= 16'h0000;
      word      <= 16'h0000;
      exc       <= 1'b0;
      ex_code   <= 8'h00;
      wait_cnt  <= 8'h00;
      lat       <= 32'h0;
      TX_VALID  <= 1'b0;
      TX_DATA   <= 8'h00;
      TX_LAST   <= 1'b0;
      REG_RD    <= 1'b0;
      BCAST_DONE <= 1'b0;
      REG_ADDR  <= 16'h0000;
      REG_INPUT <= 1'b0;
    end else begin
      state     <= next_state;
      rx_cnt    <= next_rx_cnt;
      hdr       <= next_hdr;
      crc       <= next_crc;
      tx_crc    <= next_tx_crc;
      tx_idx    <= next_tx_idx;
      nregs     <= next_nregs;
      cur       <= next_cur;
      word      <= next_word;
      exc       <= next_exc;
      ex_code   <= next_ex_code;
      wait_cnt  <= next_wait_cnt;
      lat       <= next_lat;
      TX_VALID  <= next_tx_valid;
      TX_DATA   <= next_tx_data;
      TX_LAST   <= next_tx_last;
      REG_RD    <= next_reg_rd;
      BCAST_DONE <= next_bcast;
      REG_ADDR  <= next_cur;
      REG_INPUT <= (hdr[1] == FC_READ_INPUT);
    end
  end

  // ==========================================================
  // refresh scheduler: one millisecond tick feeds all periods
  logic [31:0] ms_div, next_ms_div;
  logic [15:0] t_fast, t_harm, t_slow, next_t_fast, next_t_harm, next_t_slow;
  logic        tick;
  always_comb begin
    tick        = (ms_div == 32'(MS_CYCLES - 1));
    next_ms_div = tick ? 32'h0 : ms_div + 32'h1;
    next_t_fast = t_fast;
    next_t_harm = t_harm;
    next_t_slow = t_slow;
    if (tick) begin
      next_t_fast = (t_fast == 16'(FAST_MS - 1)) ? 16'h0 : t_fast + 16'h1;
      next_t_harm = (t_harm == 16'(HARM_MS - 1)) ? 16'h0 : t_harm + 16'h1;
      next_t_slow = (t_slow == 16'(SLOW_MS - 1)) ? 16'h0 : t_slow + 16'h1;
    end
  end

  always_ff @(posedge CLOCK or posedge RESET) begin
    if (RESET) begin
      ms_div         <= 32'h0;
      t_fast         <= 16'h0;
      t_harm         <= 16'h0;
      t_slow         <= 16'h0;
      REFRESH_FAST   <= 1'b0;
      REFRESH_HARM   <= 1'b0;
      REFRESH_SLOW   <= 1'b0;
      REFRESH_CHANGE <= 1'b0;
    end else begin
      ms_div         <= next_ms_div;
      t_fast         <= next_t_fast;
      t_harm         <= next_t_harm;
      t_slow         <= next_t_slow;
      // same strobes serve dataset and device copies
      REFRESH_FAST   <= tick && t_fast == 16'(FAST_MS - 1);
      REFRESH_HARM   <= tick && t_harm == 16'(HARM_MS - 1);
      REFRESH_SLOW   <= tick && t_slow == 16'(SLOW_MS - 1);
      REFRESH_CHANGE <= CHANGE_EVENT;
    end
  end

  // ==========================================================
  // checks
  default clocking @(posedge CLOCK); endclocking
  default disable iff (RESET);
  chk_reply_latency: assert property (
    (state == MSFH_FETCH || state == MSFH_SEND) |-> lat < 32'(REPLY_CYCLES))
    else $error("reply exceeded latency budget");
  chk_no_bcast_tx: assert property (
    BCAST_DONE |-> !TX_VALID && state == MSFH_IDLE)
    else $error("reply during broadcast");
  chk_tx_only_reply: assert property (
    $rose(TX_VALID) |-> $past(state) == MSFH_SEND || $past(state) == MSFH_CRC)
    else $error("unsolicited transmit");
  chk_fetch_first: assert property (
    (state == MSFH_RECV && next_state == MSFH_FETCH) |=> REG_RD)
    else $error("reply before processing");
  chk_dataset_fast: assert property (
    (state == MSFH_FETCH && REG_DATASET && !REG_BAD) |=> state == MSFH_SEND)
    else $error("dataset read delayed");
  chk_bad_crc_drop: assert property (
    (RX_END && state == MSFH_RECV && crc != 16'h0000) |=>
      state == MSFH_IDLE && !BCAST_DONE && !REG_RD)
    else $error("bad frame acted upon");
  chk_foreign_addr: assert property (
    (RX_END && state == MSFH_RECV && hdr[0] != SLAVE_ADDR &&
     hdr[0] != ADDR_BROADCAST) |=> state == MSFH_IDLE)
    else $error("foreign frame accepted");
  chk_fast_period: assert property (
    REFRESH_FAST |-> t_fast == 16'h0 && ms_div == 32'h0)
    else $error("refresh strobe mismatch");
  chk_change_follow: assert property (
    CHANGE_EVENT |=> REFRESH_CHANGE)
    else $error("change not propagated");
endmodule
`default_nettype wire

// ===== hw/msfh_pkg.sv
// msfh_pkg: constants and types for the slave frame handler
package msfh_pkg;
  localparam int unsigned CLK_MHZ          = 250;
  localparam logic [7:0]  ADDR_BROADCAST   = 8'h00;
  localparam logic [7:0]  ADDR_UNICAST_MAX = 8'hF7;
  localparam logic [7:0]  FC_READ_HOLDING  = 8'h03;
  localparam logic [7:0]  FC_READ_INPUT    = 8'h04;
  localparam logic [7:0]  EXC_BIT          = 8'h80;
  localparam logic [7:0]  EXC_ILLEGAL_FUNC = 8'h01;
  localparam logic [7:0]  EXC_ILLEGAL_ADDR = 8'h02;
  localparam int unsigned FRAME_MAX_BYTES  = 256;
  localparam int unsigned REQ_BYTES        = 8;
  localparam int unsigned MAX_REGS         = 125;
  localparam logic [15:0] CRC_INIT         = 16'hFFFF;
  localparam logic [15:0] CRC_POLY         = 16'hA001;
  // reply budget and refresh periods
  localparam int unsigned REPLY_MS         = 10;
  localparam int unsigned FAST_S           = 1;
  localparam int unsigned HARM_S           = 3;
  localparam int unsigned SLOW_S           = 5;
  localparam int unsigned CYC_PER_MS       = CLK_MHZ * 1000;
  localparam int unsigned REPLY_CYC        = REPLY_MS * CYC_PER_MS;
  localparam int unsigned TICK_MS_CYC      = CYC_PER_MS;
  localparam int unsigned FAST_MS          = FAST_S * 1000;
  localparam int unsigned HARM_MS          = HARM_S * 1000;
  localparam int unsigned SLOW_MS          = SLOW_S * 1000;

  typedef enum logic [2:0] {
    MSFH_IDLE  = 3'b000,
    MSFH_RECV  = 3'b001,
    MSFH_DROP  = 3'b010,
    MSFH_FETCH = 3'b011,
    MSFH_SEND  = 3'b100,
    MSFH_CRC   = 3'b101
  } msfh_state_t;

  // bitwise crc16 update of one byte
  function automatic logic [15:0] msfh_crc(input logic [15:0] c,
                                           input logic [7:0]  d);
    logic [15:0] r;
    r = c ^ {8'h00, d};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction
endpackage

// ===== testbench/msfh_reg_model.sv
// msfh_reg_model: register provider on the far side of the read port
`timescale 1ns/1ps
`default_nettype none
module msfh_reg_model (
  // read request from the handler
  input  wire logic [15:0] reg_addr,
  // answer
  output logic [15:0]      reg_data,
  output logic             reg_dataset,
  output logic             reg_bad
);
  // data is a fixed pattern of the address, so every word is predictable
  assign reg_data    = {reg_addr[7:0], ~reg_addr[15:8]};
  // low addresses stand for the dataset area, answered at once
  assign reg_dataset = reg_addr < 16'h4000;
  assign reg_bad     = reg_addr >= 16'hF000;
endmodule
`default_nettype wire

// ===== testbench/testbench.sv
// testbench: master-side stimulus and checks for the frame handler
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import msfh_pkg::*;
  localparam int unsigned MS_CYC = 2;
  typedef logic [7:0] msfh_bytes_t [$];
  logic        clock, reset, rx_valid, rx_end, tx_ready, change_event;
  logic [7:0]  rx_data;
  logic        tx_valid, tx_last, reg_rd, reg_input, bcast_done;
  logic [7:0]  tx_data;
  logic [15:0] reg_addr, reg_data;
  logic        reg_dataset, reg_bad, ref_fast, ref_harm, ref_slow, ref_chg;
  int          error_cnt, compares, cyc, lat, lat_ds;
  logic        seen, f_inp, bc;
  logic [15:0] f_addr;
  msfh_bytes_t rx_q;
  msfh_frame_handler #(.MS_CYCLES(MS_CYC)) msfh_frame_handler_inst (
    .CLOCK(clock), .RESET(reset), .SLAVE_ADDR(8'h2F),
    .RX_VALID(rx_valid), .RX_DATA(rx_data), .RX_END(rx_end),
    .TX_VALID(tx_valid), .TX_DATA(tx_data), .TX_LAST(tx_last),
    .TX_READY(tx_ready), .REG_RD(reg_rd), .REG_INPUT(reg_input),
    .REG_ADDR(reg_addr), .REG_DATA(reg_data), .REG_DATASET(reg_dataset),
    .REG_BAD(reg_bad), .BCAST_DONE(bcast_done), .REFRESH_FAST(ref_fast),
    .REFRESH_HARM(ref_harm), .REFRESH_SLOW(ref_slow),
    .CHANGE_EVENT(change_event), .REFRESH_CHANGE(ref_chg));
  msfh_reg_model msfh_reg_model_inst (
    .reg_addr(reg_addr), .reg_data(reg_data),
    .reg_dataset(reg_dataset), .reg_bad(reg_bad));
  // ==========================================================
  // clock, timeout and checking helpers
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  always @(posedge clock) begin
    cyc++;
    if (cyc == 60000) begin
      error_cnt++;
      report_and_stop();
    end
  end
  task automatic report_and_stop();
    $display("compares %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t got %0h expected %0h", $time, got, exp);
    end
  endtask
  function automatic logic [15:0] crc_of(input msfh_bytes_t q);
    logic [15:0] c;
    c = CRC_INIT;
    foreach (q[i]) begin
      c = c ^ {8'h00, q[i]};
      for (int b = 0; b < 8; b++)
        c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
    end
    return c;
  endfunction
  // ==========================================================
  // one exchange: the bench is the only master and starts it
  task automatic exchange(input logic [7:0] a, input logic [7:0] f,
                          input logic [15:0] st, input logic [15:0] n,
                          input bit bad);
    msfh_bytes_t q;
    logic [15:0] c;
    bit          done;
    q = {a, f, st[15:8], st[7:0], n[15:8], n[7:0]};
    c = crc_of(q) ^ (bad ? 16'h0100 : 16'h0000);
    q.push_back(c[7:0]);
    q.push_back(c[15:8]);
    rx_q = {};
    lat = -1;
    seen = 1'b0;
    bc = 1'b0;
    done = 1'b0;
    foreach (q[i]) begin
      @(negedge clock);
      rx_valid = 1'b1;
      rx_data = q[i];
    end
    @(negedge clock);
    rx_valid = 1'b0;
    rx_end = 1'b1;
    // bounded wait stands in for the master's reply timeout
    for (int k = 0; k < 1000 && !done; k++) begin
      @(negedge clock);
      rx_end = 1'b0;
      bc = bc | bcast_done;
      if (reg_rd && !seen) begin
        seen = 1'b1;
        f_addr = reg_addr;
        f_inp = reg_input;
      end
      // stall one cycle in three so held bytes are exercised
      tx_ready = (k % 3) != 1;
      if (tx_valid && tx_ready) begin
        if (lat < 0)
          lat = k;
        rx_q.push_back(tx_data);
        done = tx_last;
      end
    end
  endtask
  task automatic check_reply(input msfh_bytes_t e);
    logic [15:0] c;
    c = crc_of(e);
    e.push_back(c[7:0]);
    e.push_back(c[15:8]);
    check(rx_q.size(), e.size());
    foreach (e[i])
      if (i < rx_q.size())
        check(rx_q[i], e[i]);
  endtask
  task automatic exp_read(input logic [7:0] f, input logic [15:0] st,
                          input logic [15:0] n);
    msfh_bytes_t e;
    logic [15:0] w, d;
    e = {8'h2F, f, 8'(2 * n)};
    for (int i = 0; i < n; i++) begin
      w = st + 16'(i);
      d = {w[7:0], ~w[15:8]};
      e.push_back(d[15:8]);
      e.push_back(d[7:0]);
    end
    check_reply(e);
  endtask
  // ==========================================================
  // scenarios
  task automatic t_reads();
    exchange(8'h2F, FC_READ_HOLDING, 16'h2EDF, 16'h0002, 1'b0);
    check(f_addr, 16'(12000 - 1));
    check(f_inp, 1'b0);
    exp_read(FC_READ_HOLDING, 16'h2EDF, 16'h0002);
    check(lat < REPLY_CYC, 1'b1);
    lat_ds = lat;
    exchange(8'h2F, FC_READ_INPUT, 16'h522C, 16'h0002, 1'b0);
    check(f_inp, 1'b1);
    exp_read(FC_READ_INPUT, 16'h522C, 16'h0002);
    check(lat_ds < lat, 1'b1);
    exchange(8'h2F, FC_READ_HOLDING, 16'h0100, 16'd125, 1'b0);
    exp_read(FC_READ_HOLDING, 16'h0100, 16'd125);
    $display("test reads done");
  endtask
  task automatic t_silent();
    logic [7:0] adr [4];
    adr = '{8'h2F, 8'h30, 8'hF8, 8'hFF};
    exchange(8'h00, FC_READ_HOLDING, 16'h0010, 16'h0001, 1'b0);
    check(bc, 1'b1);
    check(rx_q.size(), 0);
    foreach (adr[i]) begin
      exchange(adr[i], FC_READ_HOLDING, 16'h0010, 16'h0001, i == 0);
      check(rx_q.size() + bc, 0);
    end
    // an over-long frame that ends in a valid request must be dropped whole
    repeat (300) begin
      @(negedge clock);
      rx_valid = 1'b1;
      rx_data = 8'h2F;
    end
    exchange(8'h2F, FC_READ_HOLDING, 16'h0010, 16'h0001, 1'b0);
    check(rx_q.size() + bc, 0);
    $display("test silent done");
  endtask
  task automatic t_except();
    exchange(8'h2F, 8'h06, 16'h0010, 16'h0001, 1'b0);
    check_reply({8'h2F, 8'h86, EXC_ILLEGAL_FUNC});
    exchange(8'h2F, FC_READ_HOLDING, 16'h0010, 16'h0000, 1'b0);
    check_reply({8'h2F, 8'h83, EXC_ILLEGAL_ADDR});
    exchange(8'h2F, FC_READ_INPUT, 16'h0010, 16'd126, 1'b0);
    check_reply({8'h2F, 8'h84, EXC_ILLEGAL_ADDR});
    exchange(8'h2F, FC_READ_HOLDING, 16'hF000, 16'h0001, 1'b0);
    check_reply({8'h2F, 8'h83, EXC_ILLEGAL_ADDR});
    $display("test exceptions done");
  endtask
  task automatic t_refresh();
    int         last [3], gap [3];
    logic [2:0] p;
    last = '{-1, -1, -1};
    gap = '{0, 0, 0};
    for (int k = 0; k < 22000; k++) begin
      @(negedge clock);
      p = {ref_slow, ref_harm, ref_fast};
      for (int j = 0; j < 3; j++)
        if (p[j]) begin
          if (last[j] >= 0)
            gap[j] = k - last[j];
          last[j] = k;
        end
    end
    check(gap[0], FAST_MS * MS_CYC);
    check(gap[1], HARM_MS * MS_CYC);
    check(gap[2], SLOW_MS * MS_CYC);
    $display("test refresh done");
  endtask
  task automatic t_change();
    @(negedge clock);
    check(ref_chg, 1'b0);
    change_event = 1'b1;
    @(negedge clock);
    change_event = 1'b0;
    check(ref_chg, 1'b1);
    @(negedge clock);
    check(ref_chg, 1'b0);
    $display("test change done");
  endtask
  // ==========================================================
  initial begin
    reset = 1'b1;
    rx_valid = 1'b0;
    rx_end = 1'b0;
    rx_data = 8'h00;
    tx_ready = 1'b0;
    change_event = 1'b0;
    error_cnt = 0;
    compares = 0;
    cyc = 0;
    repeat (20) @(negedge clock);
    reset = 1'b0;
    t_reads();
    t_silent();
    t_except();
    t_change();
    t_refresh();
    report_and_stop();
  end
endmodule
`default_nettype wire
